// >>> rrc_consts.svh
// Purpose: constants for the run/stop and I/O image controller
// Assumes: 250 MHz system clock
// Notes: times in their own unit; link reset count derived from them, init and flash counts given directly
`ifndef RRC_CONSTS_SVH
`define RRC_CONSTS_SVH
`define RRC_CLK_MHZ 250
`define RRC_RESET_MS_MIN 40
`define RRC_RESET_MS_MAX 100
// Least time rounds up; a whole number of cycles already
`define RRC_LINK_RESET_CYC (`RRC_RESET_MS_MIN * 1000 * `RRC_CLK_MHZ)
`define RRC_NUM_DI 24
`define RRC_NUM_AI 8
`define RRC_NUM_DQ 16
`define RRC_NUM_AQ 2
`define RRC_NUM_FLAG 24
`define RRC_NUM_AMARK 6
`define RRC_NUM_SHIFT 8
`define RRC_NUM_KEY 4
`define RRC_NUM_BLANK 16
`define RRC_BASE_DI 8
`define RRC_BASE_DQ 4
`define RRC_MAX_MOD 7
`define RRC_BUS_BITS 4
`define RRC_AW 10
`define RRC_INIT_CYC 16
`define RRC_FLASH_CYC 1024
`endif

// >>> rrc_pkg.sv
// Purpose: types for the run/stop and I/O image controller
// Assumes: constants come from rrc_consts.svh
// Notes: none
package rrc_pkg;
    typedef enum logic [1:0]
    {
        RRC_HALT = 2'b00,
        RRC_SAMPLE = 2'b01,
        RRC_EVAL = 2'b10,
        RRC_UPDATE = 2'b11
    } rrc_run_e;
    typedef enum logic [1:0]
    {
        RRC_LED_OFF = 2'b00,
        RRC_LED_GREEN = 2'b01,
        RRC_LED_RED = 2'b10,
        RRC_LED_ORANGE = 2'b11
    } rrc_led_e;
    // Block ops; unused inputs take a neutral value per op
    typedef enum logic [2:0]
    {
        RRC_OP_AND = 3'b000,
        RRC_OP_OR = 3'b001,
        RRC_OP_NAND = 3'b010,
        RRC_OP_NOR = 3'b011,
        RRC_OP_XOR = 3'b100,
        RRC_OP_NOT = 3'b101
    } rrc_op_e;
    typedef enum logic [1:0]
    {
        RRC_SRC_SIG = 2'b00,
        RRC_SRC_TRUE = 2'b01,
        RRC_SRC_FALSE = 2'b10,
        RRC_SRC_UNUSED = 2'b11
    } rrc_src_e;
endpackage

// >>> rrc_mod_led.sv
// Purpose: status indicator of one expansion module
// Assumes: link_ok and init_busy are synchronous levels
// Notes: init has priority over link state
`timescale 1ns/1ps
module rrc_mod_led
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic init_busy,
    input wire logic link_ok,
    output rrc_pkg::rrc_led_e led
);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            led <= rrc_pkg::RRC_LED_ORANGE;
        else if (init_busy)
            led <= rrc_pkg::RRC_LED_ORANGE;
        else if (link_ok)
            led <= rrc_pkg::RRC_LED_GREEN;
        else
            led <= rrc_pkg::RRC_LED_RED;
    end
endmodule

// >>> rrc_blk.sv
// Purpose: one four-input logic block of the circuit program
// Assumes: sources already resolved to bits
// Notes: combinational; the caller registers the result
`timescale 1ns/1ps
`include "rrc_consts.svh"
module rrc_blk
(
    input rrc_pkg::rrc_op_e op,
    input wire logic [3:0] sig,
    input rrc_pkg::rrc_src_e [3:0] src,
    output logic y
);
    function automatic logic neutral(input rrc_pkg::rrc_op_e o);
        // Unused leg must not change the result
        neutral = (o == rrc_pkg::RRC_OP_AND || o == rrc_pkg::RRC_OP_NAND);
    endfunction
    logic [3:0] v;
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            case (src[i])
                rrc_pkg::RRC_SRC_TRUE: v[i] = 1'b1;
                rrc_pkg::RRC_SRC_FALSE: v[i] = 1'b0;
                rrc_pkg::RRC_SRC_UNUSED: v[i] = neutral(op);
                default: v[i] = sig[i];
            endcase
        end
        case (op)
            rrc_pkg::RRC_OP_AND: y = &v;
            rrc_pkg::RRC_OP_OR: y = |v;
            rrc_pkg::RRC_OP_NAND: y = ~&v;
            rrc_pkg::RRC_OP_NOR: y = ~|v;
            rrc_pkg::RRC_OP_XOR: y = ^v;
            rrc_pkg::RRC_OP_NOT: y = ~v[0];
            default: y = 1'b0;
        endcase
    end
endmodule

// >>> rrc_ctrl.sv
// Purpose: run/stop control, I/O image and program scan of the base unit
// Assumes: all inputs synchronous to SYS_CLK; program tables are static inputs
// Notes: one scan is sample, evaluate, update, repeated while running
`timescale 1ns/1ps
`include "rrc_consts.svh"
module rrc_ctrl
#(
    parameter int NUM_MOD = `RRC_MAX_MOD,
    parameter int NUM_BLK = 16,
    parameter int LINK_RESET_CYC = `RRC_LINK_RESET_CYC,
    parameter int INIT_CYC = `RRC_INIT_CYC,
    parameter int FLASH_CYC = `RRC_FLASH_CYC
)
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic RUN_REQ,
    input wire logic STOP_REQ,
    input wire logic [`RRC_BASE_DI-1:0] BASE_DI,
    input wire logic [`RRC_AW-1:0] BASE_AI0,
    input wire logic [`RRC_AW-1:0] BASE_AI1,
    input wire logic [NUM_MOD-1:0] MOD_PRESENT,
    input wire logic [NUM_MOD*3-1:0] MOD_DI_CNT,
    input wire logic [NUM_MOD*3-1:0] MOD_DQ_CNT,
    input wire logic [`RRC_NUM_DI-1:0] MOD_DI,
    input wire logic [NUM_MOD-1:0] MOD_LINK_OK,
    input wire logic [NUM_MOD-1:0] MOD_INIT_BUSY,
    input wire logic [2:0] BUS_SLOT,
    input wire logic BUS_SUPPLY_OK,
    input wire logic BUS_COMM_OK,
    input wire logic [4:0] BUS_ADDR,
    input wire logic [`RRC_BUS_BITS-1:0] BUS_DATA_IN,
    input wire logic [NUM_BLK*3-1:0] PRG_OP,
    input wire logic [NUM_BLK*16-1:0] PRG_SEL,
    input wire logic [NUM_BLK*8-1:0] PRG_SRC,
    input wire logic [NUM_BLK*5-1:0] PRG_DEST,
    output logic RUNNING,
    output logic [`RRC_BASE_DQ-1:0] BASE_DQ,
    output logic [`RRC_NUM_DQ-1:0] MOD_DQ,
    output logic [`RRC_AW-1:0] AQ0,
    output logic [`RRC_AW-1:0] AQ1,
    output logic [`RRC_BUS_BITS-1:0] BUS_DATA_OUT,
    output rrc_pkg::rrc_led_e [NUM_MOD-1:0] MOD_LED,
    output rrc_pkg::rrc_led_e BUS_LED,
    output logic [`RRC_AW-1:0] AI_IMG0,
    output logic [`RRC_AW-1:0] AI_IMG1
);
    // ************************************************************
    // Operating state
    // ************************************************************
    rrc_pkg::rrc_run_e st_q;
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            st_q <= rrc_pkg::RRC_HALT;
        else
        begin
            case (st_q)
                rrc_pkg::RRC_HALT: if (RUN_REQ && !STOP_REQ) st_q <= rrc_pkg::RRC_SAMPLE;
                rrc_pkg::RRC_SAMPLE: st_q <= STOP_REQ ? rrc_pkg::RRC_HALT : rrc_pkg::RRC_EVAL;
                rrc_pkg::RRC_EVAL: st_q <= STOP_REQ ? rrc_pkg::RRC_HALT : rrc_pkg::RRC_UPDATE;
                // Back to sampling: the scan loops
                rrc_pkg::RRC_UPDATE: st_q <= STOP_REQ ? rrc_pkg::RRC_HALT : rrc_pkg::RRC_SAMPLE;
                default: st_q <= rrc_pkg::RRC_HALT;
            endcase
        end
    end
    assign RUNNING = (st_q != rrc_pkg::RRC_HALT);

    // ************************************************************
    // Link status and installation order
    // ************************************************************
    // Modules right of the bus slave drop out when it loses supply
    logic [NUM_MOD-1:0] link_ok;
    always_comb
    begin
        for (int m = 0; m < NUM_MOD; m++)
            link_ok[m] = MOD_LINK_OK[m] && MOD_PRESENT[m] &&
                         !(!BUS_SUPPLY_OK && m > int'(BUS_SLOT));
    end

    // Consecutive numbering regardless of type
    function automatic logic [4:0] io_base(input logic [NUM_MOD*3-1:0] cnt,
                                           input int upto);
        logic [4:0] s;
        s = 5'h00;
        for (int k = 0; k < NUM_MOD; k++)
            if (k < upto && MOD_PRESENT[k])
                s = s + {2'b00, cnt[k*3 +: 3]};
        io_base = s;
    endfunction

    logic [4:0] bus_di_base;
    logic [4:0] bus_dq_base;
    assign bus_di_base = 5'(`RRC_BASE_DI) + io_base(MOD_DI_CNT, int'(BUS_SLOT));
    assign bus_dq_base = 5'(`RRC_BASE_DQ) + io_base(MOD_DQ_CNT, int'(BUS_SLOT));

    // ************************************************************
    // Output reset on link loss
    // ************************************************************
    logic [NUM_MOD-1:0] lost;
    logic [31:0] loss_cnt_q [NUM_MOD];
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            for (int m = 0; m < NUM_MOD; m++)
                loss_cnt_q[m] <= 32'h0;
        end
        else
        begin
            for (int m = 0; m < NUM_MOD; m++)
                if (link_ok[m])
                    loss_cnt_q[m] <= 32'h0;
                else if (loss_cnt_q[m] < 32'(LINK_RESET_CYC))
                    loss_cnt_q[m] <= loss_cnt_q[m] + 32'h1;
        end
    end
    always_comb
    begin
        for (int m = 0; m < NUM_MOD; m++)
            lost[m] = (loss_cnt_q[m] >= 32'(LINK_RESET_CYC));
    end

    // ************************************************************
    // Input image
    // ************************************************************
    logic [`RRC_NUM_DI-1:0] di_q;
    logic [`RRC_AW-1:0] ai0_q;
    logic [`RRC_AW-1:0] ai1_q;
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            di_q <= '0;
            ai0_q <= '0;
            ai1_q <= '0;
        end
        else if (st_q == rrc_pkg::RRC_SAMPLE)
        begin
            // One bit per terminal, 1 = voltage present
            di_q <= MOD_DI | {{(`RRC_NUM_DI-`RRC_BASE_DI){1'b0}}, BASE_DI};
            for (int b = 0; b < `RRC_BUS_BITS; b++)
                di_q[5'(bus_di_base + 5'(b))] <= BUS_DATA_IN[b] && BUS_COMM_OK;
            // Terminals 7/8 also read as first two analog inputs
            ai0_q <= BASE_AI0;
            ai1_q <= BASE_AI1;
        end
    end
    assign AI_IMG0 = ai0_q;
    assign AI_IMG1 = ai1_q;

    // ************************************************************
    // Program evaluation
    // ************************************************************
    // Signal space: 24 inputs then 24 flags, addressed by 4-bit select; selects 8-15 add 20
    logic [`RRC_NUM_FLAG-1:0] flag_q;
    logic [`RRC_NUM_DQ-1:0] q_img_q;
    logic [47:0] space;
    logic [NUM_BLK-1:0] blk_y;
    assign space = {flag_q, di_q};
    genvar g;
    for (g = 0; g < NUM_BLK; g++)
    begin : g_blk
        logic [3:0] sig;
        rrc_pkg::rrc_src_e [3:0] src;
        always_comb
        begin
            for (int i = 0; i < 4; i++)
            begin
                sig[i] = space[6'(PRG_SEL[g*16 + i*4 +: 4]) +
                               (PRG_SEL[g*16 + i*4 + 3] ? 6'd20 : 6'd0)];
                src[i] = rrc_pkg::rrc_src_e'(PRG_SRC[g*8 + i*2 +: 2]);
            end
        end
        rrc_blk u_blk
        (
            .op(rrc_pkg::rrc_op_e'(PRG_OP[g*3 +: 3])),
            .sig(sig),
            .src(src),
            .y(blk_y[g])
        );
    end

    // Results land in flags or output image only in evaluate step
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            flag_q <= '0;
            q_img_q <= '0;
        end
        else if (st_q == rrc_pkg::RRC_EVAL)
        begin
            for (int k = 0; k < NUM_BLK; k++)
            begin
                if (PRG_DEST[k*5 + 4])
                    flag_q[5'(PRG_DEST[k*5 +: 4]) + 5'd8] <= blk_y[k];
                else
                    q_img_q[PRG_DEST[k*5 +: 4]] <= blk_y[k];
            end
        end
    end

    // ************************************************************
    // Physical outputs
    // ************************************************************
    logic [`RRC_NUM_DQ-1:0] mod_mask;
    always_comb
    begin
        mod_mask = '0;
        for (int m = 0; m < NUM_MOD; m++)
            if (lost[m])
                for (int b = 0; b < `RRC_NUM_DQ; b++)
                    // Module outputs sit above the base four in the image
                    if (5'(b) >= 5'(`RRC_BASE_DQ) + io_base(MOD_DQ_CNT, m) &&
                        5'(b) < 5'(`RRC_BASE_DQ) + io_base(MOD_DQ_CNT, m + 1))
                        mod_mask[b] = 1'b1;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            BASE_DQ <= '0;
            MOD_DQ <= '0;
            AQ0 <= '0;
            AQ1 <= '0;
            BUS_DATA_OUT <= '0;
        end
        else if (st_q == rrc_pkg::RRC_HALT)
        begin
            BASE_DQ <= '0;
            MOD_DQ <= '0;
            AQ0 <= '0;
            AQ1 <= '0;
            BUS_DATA_OUT <= '0;
        end
        else
        begin
            if (st_q == rrc_pkg::RRC_UPDATE)
            begin
                BASE_DQ <= q_img_q[`RRC_BASE_DQ-1:0];
                AQ0 <= ai0_q;
                AQ1 <= ai1_q;
                for (int b = 0; b < `RRC_BUS_BITS; b++)
                    BUS_DATA_OUT[b] <= q_img_q[4'(bus_dq_base + 5'(b))];
            end
            // Link loss clears outputs at once, not waiting for a scan
            for (int b = 0; b < `RRC_NUM_DQ; b++)
                if (mod_mask[b])
                    MOD_DQ[b] <= 1'b0;
                else if (st_q == rrc_pkg::RRC_UPDATE && b >= `RRC_BASE_DQ)
                    MOD_DQ[b] <= q_img_q[b];
        end
    end

    // ************************************************************
    // Indicators
    // ************************************************************
    logic [7:0] init_cnt_q;
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            init_cnt_q <= 8'h0;
        else if (init_cnt_q < 8'(INIT_CYC))
            init_cnt_q <= init_cnt_q + 8'h1;
    end
    for (g = 0; g < NUM_MOD; g++)
    begin : g_led
        rrc_mod_led u_led
        (
            .clk(SYS_CLK),
            .rst_n(RST_N),
            .init_busy(MOD_INIT_BUSY[g] || init_cnt_q < 8'(INIT_CYC)),
            .link_ok(link_ok[g]),
            .led(MOD_LED[g])
        );
    end

    logic [15:0] flash_cnt_q;
    logic flash_q;
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            flash_cnt_q <= 16'h0;
            flash_q <= 1'b0;
        end
        else if (flash_cnt_q >= 16'(FLASH_CYC - 1))
        begin
            flash_cnt_q <= 16'h0;
            flash_q <= !flash_q;
        end
        else
            flash_cnt_q <= flash_cnt_q + 16'h1;
    end
    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
            BUS_LED <= rrc_pkg::RRC_LED_RED;
        else if (BUS_ADDR == 5'h00)
            BUS_LED <= flash_q ? rrc_pkg::RRC_LED_ORANGE : rrc_pkg::RRC_LED_RED;
        else if (BUS_COMM_OK && BUS_SUPPLY_OK)
            BUS_LED <= rrc_pkg::RRC_LED_GREEN;
        else
            BUS_LED <= rrc_pkg::RRC_LED_RED;
    end

    // ************************************************************
    // Checks
    // ************************************************************
    halt_outputs_off_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_q == rrc_pkg::RRC_HALT && $past(st_q) == rrc_pkg::RRC_HALT |->
            BASE_DQ == '0 && MOD_DQ == '0)
        else $error("outputs on while halted");
    halt_image_kept_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_q == rrc_pkg::RRC_HALT |=> $stable(di_q))
        else $error("input image changed while halted");
    halt_no_eval_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_q != rrc_pkg::RRC_EVAL |=> $stable(flag_q) && $stable(q_img_q))
        else $error("program evaluated outside evaluate step");
    scan_order_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_q == rrc_pkg::RRC_SAMPLE && !STOP_REQ ##1 !STOP_REQ |=> st_q == rrc_pkg::RRC_UPDATE)
        else $error("scan order broken");
    scan_loops_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_q == rrc_pkg::RRC_UPDATE && !STOP_REQ |=> st_q == rrc_pkg::RRC_SAMPLE)
        else $error("scan did not repeat");
    stop_halts_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        RUNNING && STOP_REQ |=> !RUNNING)
        else $error("stop not honoured");
    addr_zero_led_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        BUS_ADDR == 5'h00 |=> BUS_LED != rrc_pkg::RRC_LED_GREEN)
        else $error("green led with address zero");
    loss_clears_a: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        mod_mask[4] |=> !MOD_DQ[4])
        else $error("output kept after link loss");
    run_cover_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        st_q == rrc_pkg::RRC_UPDATE ##1 st_q == rrc_pkg::RRC_SAMPLE);
    stop_cover_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N)
        RUNNING ##1 !RUNNING);
    loss_cover_c: cover property (@(posedge SYS_CLK) disable iff (!RST_N) |lost);
endmodule

// >>> rrc_far_model.sv
// Purpose: far side of the controller: expansion chain and field-bus master
// Assumes: bench steers faults through the control inputs
// Notes: init takes INIT_LEN cycles after reset, so the chain answers slowly
`timescale 1ns/1ps
module rrc_far_model
#(
    parameter int NUM_MOD = 7,
    parameter int INIT_LEN = 12
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_MOD-1:0] drop_link,
    input wire logic supply_cut,
    input wire logic comm_bad,
    input wire logic [4:0] addr,
    input wire logic [3:0] data,
    output logic [NUM_MOD-1:0] link_ok,
    output logic [NUM_MOD-1:0] init_busy,
    output logic supply_ok,
    output logic comm_ok,
    output logic [4:0] bus_addr,
    output logic [3:0] bus_data
);
    int init_cnt_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            init_cnt_q <= 0;
            init_busy <= '1;
            link_ok <= '0;
        end
        else
        begin
            if (init_cnt_q < INIT_LEN)
                init_cnt_q <= init_cnt_q + 1;
            init_busy <= {NUM_MOD{init_cnt_q < INIT_LEN}};
            link_ok <= {NUM_MOD{init_cnt_q >= INIT_LEN}} & ~drop_link;
        end
    end
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            supply_ok <= 1'b0;
            comm_ok <= 1'b0;
            bus_addr <= 5'h00;
            bus_data <= 4'h0;
        end
        else
        begin
            supply_ok <= ~supply_cut;
            comm_ok <= ~comm_bad & ~supply_cut;
            bus_addr <= addr;
            // Lost master leaves the data lines toggling, never a stale value
            bus_data <= comm_ok ? data : ~bus_data;
        end
    end
endmodule

// >>> test_relay_controller_run_stop_io.sv
// Purpose: self-checking bench of the run/stop and I/O image controller
// Assumes: short link reset and flash counts; three modules, bus slave in slot 1
// Notes: drivers queue notes, a monitor compares them at the falling edge
`timescale 1ns/1ps
module test_relay_controller_run_stop_io;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic RUN_REQ = 1'b0, STOP_REQ = 1'b0;
    logic [7:0] BASE_DI = 8'h00;
    logic [9:0] BASE_AI0 = 10'h000, BASE_AI1 = 10'h000;
    logic [23:0] MOD_DI = 24'h000000;
    logic [6:0] MOD_PRESENT = 7'h07;
    logic [20:0] MOD_DI_CNT = 21'h000124, MOD_DQ_CNT = 21'h000124;
    logic [2:0] BUS_SLOT = 3'h1;
    logic [6:0] drop_link = 7'h00, MOD_LINK_OK, MOD_INIT_BUSY;
    logic supply_cut = 1'b0, comm_bad = 1'b0, BUS_SUPPLY_OK, BUS_COMM_OK;
    logic [4:0] far_addr = 5'h05, BUS_ADDR;
    logic [3:0] far_data = 4'h0, BUS_DATA_IN, BASE_DQ, BUS_DATA_OUT;
    logic RUNNING, flash_clr = 1'b1, seen_r, seen_o;
    logic [15:0] MOD_DQ;
    logic [9:0] AQ0, AQ1, AI_IMG0, AI_IMG1, ai_last;
    rrc_pkg::rrc_led_e [6:0] MOD_LED;
    rrc_pkg::rrc_led_e BUS_LED;
    int failures = 0, samples_checked = 0, cyc = 0, id;
    int id_q[$];
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [31:0] r = 32'he1b011d9;
    always #2 SYS_CLK = ~SYS_CLK;
    rrc_far_model #(.NUM_MOD(7), .INIT_LEN(12)) far
    (
        .clk(SYS_CLK), .rst_n(RST_N), .drop_link(drop_link), .supply_cut(supply_cut),
        .comm_bad(comm_bad), .addr(far_addr), .data(far_data), .link_ok(MOD_LINK_OK),
        .init_busy(MOD_INIT_BUSY), .supply_ok(BUS_SUPPLY_OK), .comm_ok(BUS_COMM_OK),
        .bus_addr(BUS_ADDR), .bus_data(BUS_DATA_IN)
    );
    // Blocks: AND, NAND with true, OR with false, XOR with terminal 8, two constants,
    // NOR into a flag, NOT of that flag onto MOD_DQ[5]
    rrc_ctrl #(.NUM_MOD(7), .NUM_BLK(8), .LINK_RESET_CYC(20), .FLASH_CYC(4)) dut
    (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .RUN_REQ(RUN_REQ), .STOP_REQ(STOP_REQ),
        .BASE_DI(BASE_DI), .BASE_AI0(BASE_AI0), .BASE_AI1(BASE_AI1),
        .MOD_PRESENT(MOD_PRESENT), .MOD_DI_CNT(MOD_DI_CNT), .MOD_DQ_CNT(MOD_DQ_CNT),
        .MOD_DI(MOD_DI), .MOD_LINK_OK(MOD_LINK_OK), .MOD_INIT_BUSY(MOD_INIT_BUSY),
        .BUS_SLOT(BUS_SLOT), .BUS_SUPPLY_OK(BUS_SUPPLY_OK), .BUS_COMM_OK(BUS_COMM_OK),
        .BUS_ADDR(BUS_ADDR), .BUS_DATA_IN(BUS_DATA_IN),
        .PRG_OP({3'h5, 3'h3, 3'h0, 3'h0, 3'h4, 3'h1, 3'h2, 3'h0}),
        .PRG_SEL({16'h000c, 16'h0054, 16'h0000, 16'h0000, 16'h0070, 16'h0003, 16'h0002,
                  16'h0010}),
        .PRG_SRC({8'hfc, 8'hf0, 8'hfd, 8'hfd, 8'hf0, 8'hf8, 8'hf4, 8'hf0}),
        .PRG_DEST({5'h05, 5'h10, 5'h08, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00}),
        .RUNNING(RUNNING), .BASE_DQ(BASE_DQ), .MOD_DQ(MOD_DQ), .AQ0(AQ0), .AQ1(AQ1),
        .BUS_DATA_OUT(BUS_DATA_OUT), .MOD_LED(MOD_LED), .BUS_LED(BUS_LED),
        .AI_IMG0(AI_IMG0), .AI_IMG1(AI_IMG1)
    );
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h00000000);
    endfunction
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    task automatic note(input int k, input logic [15:0] v);
        id_q.push_back(k);
        exp_q.push_back(v);
    endtask
    task automatic cmp_bits(input string nm, input logic [15:0] x, input logic [15:0] g);
        samples_checked++;
        if (g !== x)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic cmp_led(input string nm, input rrc_pkg::rrc_led_e x,
                           input rrc_pkg::rrc_led_e g);
        samples_checked++;
        if (g !== x)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************************************
    // Monitor and watchdog
    // ****************************************
    always @(negedge SYS_CLK)
    begin
        while (id_q.size() > 0)
        begin
            id = id_q.pop_front();
            e = exp_q.pop_front();
            case (id)
                0: cmp_bits("RUNNING", e, {15'h0000, RUNNING});
                1: cmp_bits("BASE_DQ", e, {12'h000, BASE_DQ});
                2: cmp_bits("MOD_DQ", e, MOD_DQ);
                3: cmp_bits("AI_IMG0", e, {6'h00, AI_IMG0});
                4: cmp_bits("BUS_DATA_OUT", e, {12'h000, BUS_DATA_OUT});
                14: cmp_bits("AQ0", e, {6'h00, AQ0});
                15: cmp_bits("AQ1", e, {6'h00, AQ1});
                16: cmp_bits("AI_IMG1", e, {6'h00, AI_IMG1});
                12: cmp_led("BUS_LED", rrc_pkg::rrc_led_e'(e[1:0]), BUS_LED);
                13: cmp_bits("flash", e, {15'h0000, seen_r & seen_o});
                default: cmp_led("MOD_LED", rrc_pkg::rrc_led_e'(e[1:0]), MOD_LED[id-5]);
            endcase
        end
    end
    always @(posedge SYS_CLK)
    begin
        seen_r <= flash_clr ? 1'b0 : seen_r | (BUS_LED == rrc_pkg::RRC_LED_RED);
        seen_o <= flash_clr ? 1'b0 : seen_o | (BUS_LED == rrc_pkg::RRC_LED_ORANGE);
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            failures++;
            final_report();
        end
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        wait_cyc(4);
        RST_N <= 1'b1;
        wait_cyc(1);
        note(0, 16'h0000);
        note(5, 16'h0003);
        wait_cyc(30);
        note(5, 16'h0001);
        note(12, 16'h0001);
        BASE_DI <= 8'hff;
        BASE_AI0 <= 10'h155;
        MOD_DI <= 24'hffff00;
        wait_cyc(8);
        note(1, 16'h0000);
        note(2, 16'h0000);
        note(3, 16'h0000);
        RUN_REQ <= 1'b1;
        wait_cyc(1);
        RUN_REQ <= 1'b0;
        wait_cyc(1);
        note(0, 16'h0001);
        repeat (12)
        begin
            r = lfsr_next(r);
            BASE_DI <= r[7:0];
            BASE_AI0 <= r[17:8];
            BASE_AI1 <= r[27:18];
            MOD_DI <= {r[31:16], 8'h00};
            far_data <= r[11:8];
            ai_last = r[17:8];
            wait_cyc(8);
            note(1, {12'h000, r[0] ^ r[7], r[3], ~r[2], r[0] & r[1]});
            note(3, {6'h00, r[17:8]});
            note(2, {7'h00, 1'b1, 2'b00, r[4] | r[5], 1'b1, 4'h0});
            note(4, 16'h0001);
            note(14, {6'h00, r[17:8]});
            note(15, {6'h00, r[27:18]});
            note(16, {6'h00, r[27:18]});
        end
        drop_link <= 7'h01;
        wait_cyc(10);
        note(2, {7'h00, 1'b1, 2'b00, r[4] | r[5], 1'b1, 4'h0});
        note(5, 16'h0002);
        wait_cyc(15);
        note(2, 16'h0100);
        comm_bad <= 1'b1;
        wait_cyc(4);
        note(12, 16'h0002);
        comm_bad <= 1'b0;
        far_addr <= 5'h00;
        wait_cyc(4);
        flash_clr <= 1'b0;
        wait_cyc(20);
        note(13, 16'h0001);
        far_addr <= 5'h05;
        supply_cut <= 1'b1;
        wait_cyc(4);
        note(7, 16'h0002);
        supply_cut <= 1'b0;
        STOP_REQ <= 1'b1;
        wait_cyc(1);
        STOP_REQ <= 1'b0;
        wait_cyc(2);
        note(0, 16'h0000);
        note(1, 16'h0000);
        note(2, 16'h0000);
        note(14, 16'h0000);
        note(15, 16'h0000);
        BASE_AI0 <= ~ai_last;
        BASE_DI <= 8'h0f;
        wait_cyc(8);
        note(3, {6'h00, ai_last});
        note(1, 16'h0000);
        wait_cyc(2);
        final_report();
    end
endmodule
